// ### verilog/ppslc_pkg.sv
// Contract
// - Error flags 16-19 set on detection, W1C
// - Flags log regardless of reporting enables
// - Aux power bit 20 read-only, resets one
// - Transactions pending bit 21 reads zero
// - Max speed 3:0, resets to 5.0 code
// - Max width x4 upstream, x2 downstream
// - ASPM support field 11:10 resets 00b
// - L0s exit latency resets 011b
// - L1 exit latency resets 000b
// - Clock PM one upstream, zero downstream
// - Loadable defaults replaced by external loader
// - DL_Active reporting one only downstream
// - Bandwidth notify bit 21 resets zero
// - Port number resets to port index
// - Surprise-down bit 19 resets zero, loadable
// - Device control bits 0-3 enable reporting
package ppslc_pkg;
    // Register byte addresses.
    localparam logic [7:0] PPSLC_DEV_CTL_STS_ADDR = 8'hc8;
    localparam logic [7:0] PPSLC_LINK_CAP_ADDR = 8'hcc;
    localparam logic [7:0] PPSLC_IRQ_STS_ADDR = 8'he0;
    localparam logic [7:0] PPSLC_IRQ_MASK_ADDR = 8'he4;
    // Device control/status field positions.
    localparam int PPSLC_REP_EN_LSB = 0;
    localparam int PPSLC_ERR_LSB = 16;
    localparam int PPSLC_AUX_BIT = 20;
    localparam int PPSLC_TPEND_BIT = 21;
    // Link capability field positions.
    localparam int PPSLC_SPEED_LSB = 0;
    localparam int PPSLC_WIDTH_LSB = 4;
    localparam int PPSLC_ASPM_LSB = 10;
    localparam int PPSLC_L0S_LSB = 12;
    localparam int PPSLC_L1_LSB = 15;
    localparam int PPSLC_CLKPM_BIT = 18;
    localparam int PPSLC_SDOWN_BIT = 19;
    localparam int PPSLC_DLL_BIT = 20;
    localparam int PPSLC_BWN_BIT = 21;
    localparam int PPSLC_PORT_LSB = 24;
    // Reset values.
    localparam logic [3:0] PPSLC_SPEED_2G5 = 4'h1;
    localparam logic [3:0] PPSLC_SPEED_5G0 = 4'h2;
    localparam logic [5:0] PPSLC_WIDTH_UP = 6'h04;
    localparam logic [5:0] PPSLC_WIDTH_DN = 6'h02;
    localparam logic [1:0] PPSLC_ASPM_RST = 2'h0;
    localparam logic [2:0] PPSLC_L0S_RST = 3'h3;
    localparam logic [2:0] PPSLC_L1_RST = 3'h0;
    localparam logic PPSLC_AUX_RST = 1'b1;
    // Loadable default image, packed in capability field order.
    typedef struct packed {
        logic [7:0] port_num;
        logic bw_notify;
        logic surprise_down;
        logic clk_pm;
        logic [2:0] l1_exit;
        logic [2:0] l0s_exit;
        logic [1:0] aspm;
    } ppslc_load_t;
    // Bus response codes.
    localparam logic [1:0] PPSLC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PPSLC_RESP_SLVERR = 2'h2;
endpackage : ppslc_pkg

// ### verilog/ppslc_err_flags.sv
`timescale 1ns/100ps
`default_nettype none
// Four sticky error flags with write-one-to-clear.
module ppslc_err_flags (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [3:0] set_i,
    input wire logic [3:0] clr_i,
    output logic [3:0] flag_o
);
    logic [3:0] flag_q;
    logic [3:0] flag_d;

    assign flag_o = flag_q;

    ////////////////////////////////////////////////////////////////////
    // Next value per bit; a set in the clearing cycle still wins.
    always_comb begin
        flag_d = (flag_q & ~clr_i) | set_i;
    end

    // Flags reset to zero.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flag_q <= 4'h0;
        end else if (ce_i) begin
            flag_q <= flag_d;
        end
    end
endmodule : ppslc_err_flags
`default_nettype wire

// ### verilog/ppslc_regs.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Port status and link capability registers behind AXI4-Lite.
module ppslc_regs (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [1:0] port_idx_i,
    input wire logic [3:0] err_det_i,
    input wire logic aux_pwr_i,
    input wire logic load_valid_i,
    input wire ppslc_pkg::ppslc_load_t load_data_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [3:0] err_report_o,
    output logic irq_o
);
    import ppslc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State.
    typedef struct packed {
        logic upstream;       // Port role latched after reset.
        logic role_valid;     // Role latched.
        logic [1:0] port_idx; // Latched port index.
        logic [3:0] rep_en;   // Reporting enables.
        logic aux;            // Synchronised aux power level.
        logic [2:0] aux_sync; // Pin synchroniser.
        ppslc_load_t cap;     // Loadable capability fields.
        logic cap_init;       // Loadable fields seeded from role.
        logic [3:0] irq_mask; // Interrupt mask.
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ppslc_state_t;

    ppslc_state_t s_q;
    ppslc_state_t s_d;
    logic [3:0] err_q;
    logic [3:0] err_clr;
    logic [3:0] irq_sts_q;
    logic [3:0] irq_clr;
    logic [31:0] status_word;
    logic [31:0] cap_word;
    logic do_wr;
    logic ar_take;

    ////////////////////////////////////////////////////////////////////
    // Error flags and matching interrupt status, one instance each.
    ppslc_err_flags u_err (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .set_i(err_det_i), // Not gated by reporting enables.
        .clr_i(err_clr),
        .flag_o(err_q)
    );

    ppslc_err_flags u_irq (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .set_i(err_det_i),
        .clr_i(irq_clr),
        .flag_o(irq_sts_q)
    );

    ////////////////////////////////////////////////////////////////////
    // Read images.
    always_comb begin
        status_word = 32'h0;
        status_word[PPSLC_REP_EN_LSB +: 4] = s_q.rep_en;
        status_word[PPSLC_ERR_LSB +: 4] = err_q;
        status_word[PPSLC_AUX_BIT] = s_q.aux;
        status_word[PPSLC_TPEND_BIT] = 1'b0;
        cap_word = 32'h0;
        cap_word[PPSLC_SPEED_LSB +: 4] = PPSLC_SPEED_5G0;
        cap_word[PPSLC_WIDTH_LSB +: 6] = s_q.upstream ? PPSLC_WIDTH_UP
                                                      : PPSLC_WIDTH_DN;
        cap_word[PPSLC_ASPM_LSB +: 2] = s_q.cap.aspm;
        cap_word[PPSLC_L0S_LSB +: 3] = s_q.cap.l0s_exit;
        cap_word[PPSLC_L1_LSB +: 3] = s_q.cap.l1_exit;
        // Clock PM is hardwired off downstream.
        cap_word[PPSLC_CLKPM_BIT] = s_q.upstream & s_q.cap.clk_pm;
        cap_word[PPSLC_SDOWN_BIT] = s_q.cap.surprise_down;
        cap_word[PPSLC_DLL_BIT] = ~s_q.upstream;
        cap_word[PPSLC_BWN_BIT] = s_q.cap.bw_notify;
        cap_word[PPSLC_PORT_LSB +: 8] = s_q.cap.port_num;
    end

    ////////////////////////////////////////////////////////////////////
    // Bus handshakes: take each write channel once, answer after both.
    assign s_axi_awready = ~s_q.aw_got & ~s_q.bvalid;
    assign s_axi_wready = ~s_q.w_got & ~s_q.bvalid;
    assign s_axi_arready = ~s_q.rvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign err_report_o = err_q & s_q.rep_en;
    assign irq_o = |(irq_sts_q & s_q.irq_mask);
    assign do_wr = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
    assign ar_take = s_axi_arvalid & ~s_q.rvalid;

    // Write-one-to-clear strobes: error flags on byte lane 2, interrupt status on byte lane 0.
    always_comb begin
        err_clr = 4'h0;
        irq_clr = 4'h0;
        if (do_wr && s_q.w_strb[2]) begin
            if (s_q.aw_addr == PPSLC_DEV_CTL_STS_ADDR) begin
                err_clr = s_q.w_data[PPSLC_ERR_LSB +: 4];
            end
        end
        if (do_wr && s_q.w_strb[0]) begin
            if (s_q.aw_addr == PPSLC_IRQ_STS_ADDR) begin
                irq_clr = s_q.w_data[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        s_d = s_q;
        // Aux power pin: three flops, change once stages two and three agree.
        s_d.aux_sync = {s_q.aux_sync[1:0], aux_pwr_i};
        if (s_q.aux_sync[2] == s_q.aux_sync[1]) begin
            s_d.aux = s_q.aux_sync[2];
        end
        // Latch the port role once after reset release.
        if (!s_q.role_valid) begin
            s_d.role_valid = 1'b1;
            s_d.port_idx = port_idx_i;
            s_d.upstream = (port_idx_i == 2'h0);
        end else if (!s_q.cap_init) begin
            // Seed the loadable defaults from the role.
            s_d.cap_init = 1'b1;
            s_d.cap.clk_pm = s_q.upstream;
            s_d.cap.port_num = {6'h00, s_q.port_idx};
        end
        // External loader overrides the defaults.
        if (load_valid_i && s_q.cap_init) begin
            s_d.cap = load_data_i;
        end
        // Write channels.
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_got = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (do_wr) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = PPSLC_RESP_OKAY;
            case (s_q.aw_addr)
                PPSLC_DEV_CTL_STS_ADDR: begin
                    if (s_q.w_strb[0]) begin
                        s_d.rep_en = s_q.w_data[PPSLC_REP_EN_LSB +: 4];
                    end
                end
                PPSLC_LINK_CAP_ADDR: begin
                    // Read-only: write is ignored.
                end
                PPSLC_IRQ_STS_ADDR: begin
                    // Handled by the clear strobes.
                end
                PPSLC_IRQ_MASK_ADDR: begin
                    if (s_q.w_strb[0]) begin
                        s_d.irq_mask = s_q.w_data[3:0];
                    end
                end
                default: begin
                    s_d.bresp = PPSLC_RESP_SLVERR;
                end
            endcase
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // Read channel: data registered one cycle after address.
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (ar_take) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = PPSLC_RESP_OKAY;
            case (s_axi_araddr)
                PPSLC_DEV_CTL_STS_ADDR: s_d.rdata = status_word;
                PPSLC_LINK_CAP_ADDR: s_d.rdata = cap_word;
                PPSLC_IRQ_STS_ADDR: s_d.rdata = {28'h0, irq_sts_q};
                PPSLC_IRQ_MASK_ADDR: s_d.rdata = {28'h0, s_q.irq_mask};
                default: begin
                    s_d.rdata = 32'h0;
                    s_d.rresp = PPSLC_RESP_SLVERR;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register; constants only under reset.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
            s_q.upstream <= 1'b1;
            s_q.aux <= PPSLC_AUX_RST;
            s_q.aux_sync <= {3{PPSLC_AUX_RST}};
            s_q.cap.aspm <= PPSLC_ASPM_RST;
            s_q.cap.l0s_exit <= PPSLC_L0S_RST;
            s_q.cap.l1_exit <= PPSLC_L1_RST;
            s_q.cap.surprise_down <= 1'b0;
            s_q.cap.bw_notify <= 1'b0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end
endmodule : ppslc_regs
`default_nettype wire

// ### testbench/ppslc_regs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Watches bus handshakes, sticky error flags and the interrupt line.
module ppslc_regs_mon
    import ppslc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] err_det_i,
    input wire logic [3:0] err_report_o,
    input wire logic irq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    logic hit_q; // Write data taken or answer standing last cycle.
    // A write may commit on the edge after its data is taken.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= (s_axi_wvalid && s_axi_wready) || s_axi_bvalid;
        end
    end
    wire logic wr_hit = hit_q | s_axi_bvalid;
    ////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_read_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
    a_write_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("bvalid lost");
    a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready
        && !s_axi_wready) else $error("write taken while busy");
    a_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp ==
        PPSLC_RESP_SLVERR |-> s_axi_rdata == 32'h0) else $error("bad rdata");
    a_flag_sticky: assert property (
        |($past(err_report_o) & ~err_report_o) |-> wr_hit)
        else $error("flag dropped without write");
    a_flag_cause: assert property (
        |(err_report_o & ~$past(err_report_o)) |-> $past(|err_det_i)
        || wr_hit) else $error("flag rose without cause");
    a_irq_cause: assert property ($rose(irq_o) |-> $past(|err_det_i)
        || wr_hit) else $error("irq rose without cause");
    a_irq_drop: assert property ($fell(irq_o) |-> wr_hit)
        else $error("irq fell without write");
endmodule : ppslc_regs_mon
bind ppslc_regs ppslc_regs_mon u_ppslc_regs_mon (.mclk_i, .sys_rst_i,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .err_det_i,
    .err_report_o, .irq_o);
`default_nettype wire

// ### testbench/ppslc_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Register bench: capability resets per port, flags, irq and bus errors.
module ppslc_regs_tb_top;
    import ppslc_pkg::*;
    logic mclk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, aux_pwr_i = 1'b1;
    logic [1:0] port_idx_i = 2'h0;
    logic [3:0] err_det_i = 4'h0, s_axi_wstrb = 4'hf, err_report_o;
    logic load_valid_i = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    ppslc_load_t load_data_i = '0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq_o;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int n_fail = 0;
    int check_count = 0;
    always #2.5 mclk_i = ~mclk_i; // 200 MHz.
    ppslc_regs u_ppslc_regs (.mclk_i, .sys_rst_i, .ce_i, .port_idx_i,
        .err_det_i, .aux_pwr_i, .load_valid_i, .load_data_i, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .err_report_o, .irq_o);
    ////////////////////////////////////////////////////////////////////
    // Compares one value and counts the outcome.
    task chk(input string nm, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One write; both channels offered together, each dropped once taken.
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64 && !s_axi_bvalid; n++) begin
            @(posedge mclk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 64) chk("write answer", 32'h1, 32'h0);
    endtask : wr
    // One read; data and response taken at the edge rvalid is seen.
    task rd(input logic [7:0] a);
        int n;
        @(posedge mclk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64 && !s_axi_rvalid; n++) begin
            @(posedge mclk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        rd_data = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 64) chk("read answer", 32'h1, 32'h0);
    endtask : rd
    // Lets the edge's updates land before a combinational output is read.
    task settle;
        @(posedge mclk_i);
        #1;
    endtask : settle
    task pulse(input logic [3:0] v);
        @(posedge mclk_i);
        err_det_i <= v;
        @(posedge mclk_i);
        err_det_i <= 4'h0;
    endtask : pulse
    // Expected capability word; a load image of all ones and port 5a.
    function automatic logic [31:0] caps(input logic [1:0] p, input logic ld);
        return {ld ? 8'h5a : {6'h0, p}, 2'h0, ld, p != 2'h0, ld, p == 2'h0,
            ld ? 3'h7 : PPSLC_L1_RST, ld ? 3'h7 : PPSLC_L0S_RST,
            ld ? 2'h3 : PPSLC_ASPM_RST,
            p == 2'h0 ? PPSLC_WIDTH_UP : PPSLC_WIDTH_DN, PPSLC_SPEED_5G0};
    endfunction : caps
    ////////////////////////////////////////////////////////////////////
    // Resets as the given port, then checks defaults, read-only, loading.
    task t_caps(input logic [1:0] p);
        @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        port_idx_i <= p;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rd(PPSLC_DEV_CTL_STS_ADDR);
        chk("status reset", 32'h0010_0000, rd_data);
        rd(PPSLC_LINK_CAP_ADDR);
        chk("caps reset", caps(p, 1'b0), rd_data);
        chk("caps reset", caps(p, 1'b0), rd_data);
        chk("caps reset", caps(p, 1'b0), rd_data);
        wr(PPSLC_LINK_CAP_ADDR, 32'hffff_ffff);
        rd(PPSLC_LINK_CAP_ADDR);
        chk("caps read only", caps(p, 1'b0), rd_data);
        @(posedge mclk_i);
        load_valid_i <= 1'b1;
        load_data_i <= {8'h5a, 11'h7ff};
        @(posedge mclk_i);
        load_valid_i <= 1'b0;
        rd(PPSLC_LINK_CAP_ADDR);
        chk("caps loaded", caps(p, 1'b1), rd_data);
    endtask : t_caps
    // Logging while disabled, zero write, clear, and set against clear.
    task t_errors;
        pulse(4'hf);
        rd(PPSLC_DEV_CTL_STS_ADDR);
        chk("flags logged", 32'h001f_0000, rd_data);
        chk("report off", 32'h0, {28'h0, err_report_o});
        wr(PPSLC_DEV_CTL_STS_ADDR, 32'h0000_000f);
        rd(PPSLC_DEV_CTL_STS_ADDR);
        chk("zero write", 32'h001f_000f, rd_data);
        chk("report on", 32'hf, {28'h0, err_report_o});
        wr(PPSLC_DEV_CTL_STS_ADDR, 32'h0001_000f);
        rd(PPSLC_DEV_CTL_STS_ADDR);
        chk("flag cleared", 32'h001e_000f, rd_data);
        // The detection is shown for exactly one edge: the one that
        // commits the clear, so a clear that wins would lose the flag.
        fork
            wr(PPSLC_DEV_CTL_STS_ADDR, 32'h0002_000f);
            begin
                do @(posedge mclk_i);
                while (!(s_axi_awvalid && s_axi_awready && s_axi_wvalid
                    && s_axi_wready));
                err_det_i <= 4'h2;
                @(posedge mclk_i);
                err_det_i <= 4'h0;
            end
        join
        rd(PPSLC_DEV_CTL_STS_ADDR);
        chk("set beats clear", 32'h001e_000f, rd_data);
    endtask : t_errors
    // Interrupt masked, unmasked, cleared, raised again.
    task t_irq;
        rd(PPSLC_IRQ_STS_ADDR);
        chk("irq status", 32'hf, rd_data);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        wr(PPSLC_IRQ_MASK_ADDR, 32'h1);
        settle;
        chk("irq unmasked", 32'h1, {31'h0, irq_o});
        wr(PPSLC_IRQ_STS_ADDR, 32'h1);
        settle;
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        pulse(4'h1);
        settle;
        chk("irq again", 32'h1, {31'h0, irq_o});
        rd(8'h10);
        chk("unmapped data", 32'h0, rd_data);
        chk("unmapped resp", {30'h0, PPSLC_RESP_SLVERR}, {30'h0, rsp});
    endtask : t_irq
    ////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    initial begin
        for (int p = 0; p < 3; p++) t_caps(p[1:0]);
        t_errors;
        t_irq;
        report_and_stop;
    end
    // The run needs well under 2000 cycles; a hang ends it here.
    initial begin
        #(5 * 5000);
        n_fail++;
        report_and_stop;
    end
endmodule : ppslc_regs_tb_top
`default_nettype wire
